// file: ccpif_flag_reg.v
// channel event flag register with ahb-lite slave, mode select and masked interrupt
//
// What this block does
// RQ1: bits 7 to 5 read zero, ignore writes
// RQ2: channel n flag at bit n-1
// RQ3: capture mode: capture event sets flag
// RQ4: compare mode: compare match sets flag
// RQ5: pwm mode: output trailing edge sets flag
// RQ6: flag holds until software writes zero
// RQ7: flags set regardless of any enable
// RQ8: software clears flag before enabling interrupt
// RQ9: every reset clears all flags
// RQ10: flags read/write; writing one also sets
// RQ11: hardware set beats same-cycle software clear
`timescale 1ns/1ps
`include "ccpif_map.vh"

module ccpif_flag_reg #(
  parameter NUM_CHAN = `CCPIF_NUM_CHAN
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // raw channel conditions, same clock domain
  input wire [NUM_CHAN-1:0] capture_event,
  input wire [NUM_CHAN-1:0] compare_match,
  input wire [NUM_CHAN-1:0] pwm_out,
  // flags towards the processor interrupt logic
  output wire [NUM_CHAN-1:0] channel_event_flags,
  // masked interrupt request
  output wire irq
);

  localparam MW = NUM_CHAN * `CCPIF_MODE_BITS; // width of the mode field

  // live registers
  reg [NUM_CHAN-1:0] flags; // channel_event_flags
  reg [MW-1:0] channel_mode_select; // two mode bits per channel
  reg [NUM_CHAN-1:0] irq_status; // sticky event record, read clears
  reg [NUM_CHAN-1:0] irq_mask; // one enables the status bit onto irq

  // captured address phase
  reg wr_pend; // write data phase in progress
  reg [7:0] wr_ofs; // offset of the pending write

  // next values
  reg [NUM_CHAN-1:0] next_flags;
  reg [MW-1:0] next_mode;
  reg [NUM_CHAN-1:0] next_status;
  reg [NUM_CHAN-1:0] next_mask;
  reg [31:0] next_hrdata;

  wire [NUM_CHAN-1:0] chan_event; // one-cycle set requests per channel

  // one qualifier per channel, mode slice picked by index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
      ccpif_chan_event u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(channel_mode_select[gi*`CCPIF_MODE_BITS +: `CCPIF_MODE_BITS]),
        .capture_event(capture_event[gi]),
        .compare_match(compare_match[gi]),
        .pwm_out(pwm_out[gi]),
        .event_pulse(chan_event[gi]) // RQ2
      );
    end
  endgenerate

  // address phase accepted: selected, bus ready, nonseq transfer
  wire addr_ok = hsel & hready & (htrans == `CCPIF_HTRANS_NONSEQ);
  wire rd_take = addr_ok & ~hwrite;
  wire [7:0] rd_ofs = haddr[7:0];
  wire wr_hit = wr_pend;

  // always ready, always okay: every access finishes with no wait state
  assign hreadyout = 1'b1;
  assign hresp = `CCPIF_HRESP_OKAY;

  // register update; events or'd in last so a set always wins
  always @* begin
    next_flags = flags;
    next_mode = channel_mode_select;
    next_status = irq_status;
    next_mask = irq_mask;
    if (wr_hit) begin
      case (wr_ofs)
        `CCPIF_OFS_FLAGS: begin
          // only implemented bits are taken, upper bits dropped
          next_flags = hwdata[`CCPIF_FLAG_MSB:`CCPIF_FLAG_LSB]; // RQ1 RQ6 RQ10
        end
        `CCPIF_OFS_MODE: begin
          next_mode = hwdata[MW-1:0];
        end
        `CCPIF_OFS_MASK: begin
          next_mask = hwdata[NUM_CHAN-1:0];
        end
        default: begin
          // status is read-clear only; unmapped writes are dropped
          next_flags = flags;
        end
      endcase
    end
    // a read of status clears it; the read data is irq_status as held before the clear
    if (rd_take && rd_ofs == `CCPIF_OFS_STATUS) begin
      next_status = {NUM_CHAN{1'b0}};
    end
    // no enable gates the set path
    next_flags = next_flags | chan_event; // RQ7 RQ11
    next_status = next_status | chan_event; // RQ11
  end

  // read data built from post-write values so a read right after a write sees it
  always @* begin
    next_hrdata = 32'h0000_0000;
    case (rd_ofs)
      `CCPIF_OFS_FLAGS: begin
        // upper bits of the byte and word stay zero
        next_hrdata[NUM_CHAN-1:0] = (wr_hit && wr_ofs == `CCPIF_OFS_FLAGS) ?
                                    hwdata[NUM_CHAN-1:0] | flags : flags; // RQ1
        if (wr_hit && wr_ofs == `CCPIF_OFS_FLAGS) begin
          next_hrdata[NUM_CHAN-1:0] = hwdata[NUM_CHAN-1:0];
        end
      end
      `CCPIF_OFS_MODE: begin
        next_hrdata[MW-1:0] = next_mode;
      end
      `CCPIF_OFS_STATUS: begin
        next_hrdata[NUM_CHAN-1:0] = irq_status;
      end
      `CCPIF_OFS_MASK: begin
        next_hrdata[NUM_CHAN-1:0] = next_mask;
      end
      default: begin
        // unmapped offsets read zero
        next_hrdata = 32'h0000_0000;
      end
    endcase
  end

  // register state; every reset source lands here
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= `CCPIF_RST_FLAGS; // RQ9
      channel_mode_select <= `CCPIF_RST_MODE;
      irq_status <= `CCPIF_RST_STATUS;
      irq_mask <= `CCPIF_RST_MASK;
    end else begin
      flags <= next_flags;
      channel_mode_select <= next_mode;
      irq_status <= next_status;
      irq_mask <= next_mask;
    end
  end

  // bus pipeline: capture write address phase, register read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_ofs <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // flags go straight out; software must clear before enabling downstream (RQ8)
  assign channel_event_flags = flags;

  // level interrupt while any unmasked sticky bit is set
  assign irq = |(irq_status & irq_mask);

endmodule

// file: ccpif_map.vh
// register map, field layout, reset values and mode codes of the channel event flag block
`ifndef CCPIF_MAP_VH
`define CCPIF_MAP_VH

// byte offsets of the word registers
`define CCPIF_OFS_FLAGS 8'h00
`define CCPIF_OFS_MODE 8'h04
`define CCPIF_OFS_STATUS 8'h08
`define CCPIF_OFS_MASK 8'h0c

// field layout of the flag register
`define CCPIF_NUM_CHAN 5
`define CCPIF_FLAG_LSB 0
`define CCPIF_FLAG_MSB 4
`define CCPIF_REG_WIDTH 8

// reset values
`define CCPIF_RST_FLAGS 5'h00
`define CCPIF_RST_MODE 10'h000
`define CCPIF_RST_STATUS 5'h00
`define CCPIF_RST_MASK 5'h00

// per-channel operating mode, two bits per channel in the mode register
`define CCPIF_MODE_BITS 2
`define CCPIF_MODE_OFF 2'h0
`define CCPIF_MODE_CAPTURE 2'h1
`define CCPIF_MODE_COMPARE 2'h2
`define CCPIF_MODE_PWM 2'h3

// ahb transfer and response codes
`define CCPIF_HTRANS_NONSEQ 2'h2
`define CCPIF_HRESP_OKAY 1'h0

`endif

// file: ccpif_chan_event.v
// one channel's event qualifier: picks the set condition by operating mode
`timescale 1ns/1ps
`include "ccpif_map.vh"

module ccpif_chan_event (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // mode from the mode register
  input wire [1:0] mode,
  // raw channel conditions, same clock domain
  input wire capture_event,
  input wire compare_match,
  input wire pwm_out,
  // one-cycle set request for the flag
  output wire event_pulse
);

  // true when the channel runs in the given mode
  function mode_is;
    input [1:0] cur;
    input [1:0] code;
    begin
      mode_is = (cur == code);
    end
  endfunction

  reg pwm_prev; // pwm level one cycle ago, for the trailing edge

  // remember the pwm level; cleared so no false edge right after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_prev <= 1'b0;
    end else begin
      pwm_prev <= pwm_out;
    end
  end

  // trailing edge is a high-to-low step of the pwm output
  wire pwm_trail = pwm_prev & ~pwm_out;

  // only the condition of the active mode may set the flag
  assign event_pulse = (mode_is(mode, `CCPIF_MODE_CAPTURE) & capture_event) | // RQ3
                       (mode_is(mode, `CCPIF_MODE_COMPARE) & compare_match) | // RQ4
                       (mode_is(mode, `CCPIF_MODE_PWM) & pwm_trail); // RQ5

endmodule

// file: ccpif_flag_monitor.sv
// port checker for the channel event flag register
`timescale 1ns/1ps
module ccpif_flag_monitor #(parameter NUM_CHAN = 5) (
  // bus side
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // channel side
  input wire [NUM_CHAN-1:0] capture_event,
  input wire [NUM_CHAN-1:0] compare_match,
  input wire [NUM_CHAN-1:0] pwm_out,
  input wire [NUM_CHAN-1:0] channel_event_flags,
  input wire irq
);
  logic acc_q, wr_q, rd_q; // data phase of any access, of a flag write, of a flag read
  logic [NUM_CHAN-1:0] pwm_q; // pwm level at the last edge
  wire go = hsel && hready && htrans == 2'h2;
  // any raw condition; mode is not visible here, so this is only a necessary cause
  wire [NUM_CHAN-1:0] cause = capture_event | compare_match | (pwm_q & ~pwm_out);
  // track data phases and the pwm level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pwm_q <= '0;
    end else begin
      acc_q <= go;
      wr_q <= go && hwrite && haddr[7:0] == 8'h00;
      rd_q <= go && !hwrite && haddr[7:0] == 8'h00;
      pwm_q <= pwm_out;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_a:
  assert property (hreadyout && !hresp) else $error("bus wait or error");
  rst_a:
  assert property ($rose(hresetn) |-> channel_event_flags == '0 && !irq) else $error("reset");
  hold_a:
  assert property (|($past(channel_event_flags) & ~channel_event_flags) |-> $past(wr_q))
    else $error("flag lost");
  rise_a:
  assert property (|(channel_event_flags & ~$past(channel_event_flags) & ~$past(cause))
    |-> $past(wr_q)) else $error("flag set with no cause");
  wset_a:
  assert property (wr_q |=> &(channel_event_flags | ~$past(hwdata[NUM_CHAN-1:0])))
    else $error("write one did not set");
  wexact_a:
  assert property (wr_q |=> ((channel_event_flags ^ $past(hwdata[NUM_CHAN-1:0]))
    & ~$past(cause)) == '0) else $error("write not applied");
  rdflag_a:
  assert property (rd_q && !$past(wr_q) |->
    hrdata == {{(32-NUM_CHAN){1'b0}}, $past(channel_event_flags)}) else $error("read data");
  irq_a:
  assert property (irq != $past(irq) |-> $past(|cause) || $past(go) || $past(acc_q))
    else $error("irq");
endmodule
bind ccpif_flag_reg ccpif_flag_monitor #(.NUM_CHAN(NUM_CHAN)) ccpif_flag_monitor_i (.*);

// file: ccpif_chan_model.sv
// channel side model: one capture, compare or pwm trailing edge on request
`timescale 1ns/1ps
module ccpif_chan_model (
  // clock
  input wire hclk,
  // raw channel conditions
  output logic [4:0] capture_event,
  output logic [4:0] compare_match,
  output logic [4:0] pwm_out
);
  // idle low
  initial begin
    capture_event = 5'h00;
    compare_match = 5'h00;
    pwm_out = 5'h00;
  end
  // kind 0 capture, 1 compare, 2 pwm pulse whose fall is the event
  task automatic fire(input int kind, input int ch);
    @(posedge hclk);
    if (kind == 0) capture_event[ch] <= 1'b1;
    else if (kind == 1) compare_match[ch] <= 1'b1;
    else pwm_out[ch] <= 1'b1;
    @(posedge hclk);
    capture_event <= 5'h00;
    compare_match <= 5'h00;
    pwm_out <= 5'h00;
    @(posedge hclk);
    // let the flag, status and irq updates of this edge settle before anyone looks
    #1;
  endtask
endmodule

// file: ccpif_flag_reg_tb.sv
// self-checking bench for the channel event flag register
`timescale 1ns/1ps
`include "ccpif_map.vh"
module ccpif_flag_reg_tb;
  logic hclk, hresetn, hsel, hwrite; // clock, reset, bus controls
  logic [31:0] haddr, hwdata, rd; // bus address, write and last read data
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  wire [4:0] cap, cmp, pwm, flags;
  int miscompares = 0;
  int samples_checked = 0;
  ccpif_flag_reg ccpif_flag_reg_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capture_event(cap), .compare_match(cmp), .pwm_out(pwm), .channel_event_flags(flags),
    .irq(irq));
  ccpif_chan_model ccpif_chan_model_i (.hclk(hclk), .capture_event(cap),
    .compare_match(cmp), .pwm_out(pwm));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // single transfer; waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `CCPIF_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic final_report;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(8'(i * 4), 32'h0);
    bus(1'b1, `CCPIF_OFS_MODE, 32'h79); // 1 capture, 2 compare, 3 pwm, 4 capture, 5 off
    ccpif_chan_model_i.fire(0, 0);
    rchk(`CCPIF_OFS_FLAGS, 32'h01);
    ccpif_chan_model_i.fire(1, 0);
    ccpif_chan_model_i.fire(0, 4);
    ccpif_chan_model_i.fire(1, 1);
    ccpif_chan_model_i.fire(2, 2);
    ccpif_chan_model_i.fire(1, 3);
    rchk(`CCPIF_OFS_FLAGS, 32'h07);
    rchk(`CCPIF_OFS_STATUS, 32'h07);
    bus(1'b1, `CCPIF_OFS_MASK, 32'h02);
    chk({31'h0, irq}, 32'h0);
    ccpif_chan_model_i.fire(1, 1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `CCPIF_OFS_MASK, 32'h00);
    chk({31'h0, irq}, 32'h0);
    rchk(`CCPIF_OFS_STATUS, 32'h02);
    bus(1'b1, `CCPIF_OFS_FLAGS, 32'hff);
    rchk(`CCPIF_OFS_FLAGS, 32'h1f);
    chk({27'h0, flags}, 32'h1f);
    bus(1'b1, `CCPIF_OFS_FLAGS, 32'h00);
    rchk(`CCPIF_OFS_FLAGS, 32'h00);
    fork
      bus(1'b1, `CCPIF_OFS_FLAGS, 32'h00);
      begin
        @(posedge hclk);
        ccpif_chan_model_i.fire(0, 3);
      end
    join
    rchk(`CCPIF_OFS_FLAGS, 32'h08);
    rchk(8'h10, 32'h0);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`CCPIF_OFS_FLAGS, 32'h00);
    final_report;
  end
endmodule
